// *** hw/mon_pkg.sv ***
// Constants, encodings and states of the monitor channel command handler.
// Assumes nothing: pure definitions shared by design and bench.
package mon_pkg;
	// Transfer command codes
	localparam logic [1:0] CMD_NONE = 2'h0;
	localparam logic [1:0] CMD_TX = 2'h1;
	localparam logic [1:0] CMD_TXRX = 2'h2;
	localparam logic [1:0] CMD_CONT = 2'h3;
	// Mode field (top bits of the target address) for code 01
	localparam logic [1:0] MODE_BCAST = 2'h1;
	localparam logic [1:0] MODE_TEST = 2'h2;
	// Field positions inside the target address
	localparam int MODE_HI = 7;
	localparam int MODE_LO = 6;
	localparam int ADDR_HI = 5;
	// Receive frame counts without handshake
	localparam logic [4:0] RXN_SEL0 = 5'h01;
	localparam logic [4:0] RXN_SEL1 = 5'h02;
	localparam logic [4:0] RXN_SEL2 = 5'h08;
	localparam logic [4:0] RXN_SEL3 = 5'h10;
	// Frames between broadcast bytes with handshake
	localparam logic [1:0] BCAST_LAST = 2'h2;
	// Upstream slot offset for same line receive
	localparam logic [5:0] SAME_LINE_OFS = 6'h04;
	// Documented FIFO depth
	localparam int FIFO_DEPTH = 16;
	// Handler states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_TX = 2'b01,
		ST_RX = 2'b10,
		ST_STALL = 2'b11
	} state_t;
endpackage

// *** hw/monitor_channel_command_handler.sv ***
// Monitor channel command handler: FIFO, transfer sequencer, search.
// Assumes link pins change at frame rate, far slower than I_CLK.
//
// Summary of operation
// - Continuous transmit keeps handshake active, requests more
// - Continuous blocks hold one to sixteen bytes
// - Transmit then receive; empty FIFO means receive only
// - Wait remote ack per byte; ack received bytes
// - Two inactive handshake frames end the message
// - Receive stores at most sixteen bytes
// - FIFO reset aborts a running receive
// - Seventeenth byte: done, unacknowledged, transfer stays active
// - Reissued receive with empty FIFO resumes reception
// - No handshake: byte per frame, 1/2/8/16 frames
// - Same line receives four slots after transmit
// - Broadcast sends on all monitor slots
// - Broadcast handshake: byte per three frames, acks ignored
// - Test makes message readable, no transmission
// - Search raises found, stops, stores address
// - Search runs beside any transfer, flags one find, then stops
// - Search stops only on find or init
// - FIFO reset empties, aborts, keeps search
`timescale 1ns/100ps
module monitor_channel_command_handler #(
	parameter int DEPTH = mon_pkg::FIFO_DEPTH,
	parameter int NCH = 32
) (
	// Clock, reset, enable
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic I_CE,
	// Processor command and control
	input wire logic I_CMD_VALID,
	input wire logic [1:0] I_TRANSFER_CMD_CODE,
	input wire logic [7:0] I_TARGET_CHANNEL_ADDR,
	input wire logic I_FIFO_RESET_CMD,
	input wire logic I_CHANNEL_SEARCH_ON,
	input wire logic I_HANDSHAKE_SELECT,
	input wire logic I_CM_INIT_SELECT,
	// FIFO write side
	input wire logic I_WR_VALID,
	input wire logic [7:0] I_WR_DATA,
	output logic O_WR_READY,
	// FIFO read side
	output logic O_RD_VALID,
	output logic [7:0] O_RD_DATA,
	input wire logic I_RD_READY,
	// Status and events
	output logic O_FIFO_EMPTY_FLAG,
	output logic O_XFER_ACTIVE,
	output logic O_XFER_ABORTED,
	output logic O_ACCESS_EN,
	output logic O_READ_MODE,
	output logic O_COMMAND_DONE_IRQ,
	output logic O_CHANNEL_FOUND_IRQ,
	output logic [5:0] O_FOUND_CHANNEL_ADDR,
	// Link pins, sampled once per frame
	input wire logic I_FRAME,
	input wire logic I_MR_N,
	input wire logic I_MX_N,
	input wire logic [7:0] I_RX_DATA,
	input wire logic [NCH-1:0] I_SCAN_MX_N,
	output logic [7:0] O_TX_DATA,
	output logic O_MX_N,
	output logic O_MR_N,
	output logic O_BCAST,
	output logic [5:0] O_TX_SLOT,
	output logic [5:0] O_RX_SLOT
);
	localparam int PW = $clog2(DEPTH);
	localparam int SW = NCH + 11;

	if (DEPTH < 2 || DEPTH > 16 || (DEPTH & (DEPTH - 1)) != 0)
		$error("DEPTH must be a power of two from 2 to 16");
	if (NCH < 1 || NCH > 64)
		$error("NCH must lie between 1 and 64");

	// Frames to collect for a receive count selection
	function automatic logic [4:0] rx_frames(input logic [1:0] sel);
		case (sel)
			2'h0: rx_frames = mon_pkg::RXN_SEL0;
			2'h1: rx_frames = mon_pkg::RXN_SEL1;
			2'h2: rx_frames = mon_pkg::RXN_SEL2;
			default: rx_frames = mon_pkg::RXN_SEL3;
		endcase
	endfunction

	// Lowest active channel of the scan vector
	function automatic logic [5:0] first_act(input logic [NCH-1:0] v);
		first_act = '0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (!v[i])
				first_act = 6'(i);
		end
	endfunction

	// Two-flop synchronisers for all link pins
	logic [SW-1:0] pin_s1_ff, pin_s2_ff;
	logic frm_d_ff;
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			pin_s1_ff <= '1;
			pin_s2_ff <= '1;
			frm_d_ff <= 1'b1;
		end else if (I_CE) begin
			pin_s1_ff <= {I_FRAME, I_MR_N, I_MX_N, I_RX_DATA, I_SCAN_MX_N};
			pin_s2_ff <= pin_s1_ff;
			frm_d_ff <= pin_s2_ff[SW-1];
		end
	end

	wire frame_p = pin_s2_ff[SW-1] & ~frm_d_ff;
	wire mr_act = ~pin_s2_ff[SW-2];
	wire mx_act = ~pin_s2_ff[SW-3];
	wire [7:0] rx_byte = pin_s2_ff[NCH+7:NCH];
	wire [NCH-1:0] scan_n = pin_s2_ff[NCH-1:0];

	// Handler state
	mon_pkg::state_t state_ff, nxt_state;
	logic [1:0] mode_ff, nxt_mode;
	logic [5:0] addr_ff, nxt_addr;
	logic hs_ff, nxt_hs, cont_ff, nxt_cont, rxa_ff, nxt_rxa;
	logic line_ff, nxt_line, wait_ff, nxt_wait, seen_ff, nxt_seen;
	logic miss_ff, nxt_miss, mx_n_ff, nxt_mx_n, mr_n_ff, nxt_mr_n;
	logic read_ff, nxt_read, abort_ff, nxt_abort, done_ff, nxt_done;
	logic [1:0] div_ff, nxt_div;
	logic [4:0] rxn_ff, nxt_rxn;
	logic [7:0] txd_ff, nxt_txd;
	logic tx_pop, rx_push;

	// FIFO storage and two-entry read buffer
	logic [7:0] mem [DEPTH];
	logic [PW-1:0] wp_ff, rp_ff;
	logic [PW:0] cnt_ff;
	logic [7:0] bd_ff [2];
	logic bh_ff;
	logic [1:0] bc_ff;

	wire fifo_empty = (cnt_ff == '0);
	wire fifo_full = (cnt_ff == (PW+1)'(DEPTH));
	wire idle_st = (state_ff == mon_pkg::ST_IDLE);
	wire stall_st = (state_ff == mon_pkg::ST_STALL);
	wire acc_en = idle_st | stall_st;
	wire rd_mode = read_ff | stall_st;
	wire cmd_go = I_CMD_VALID & acc_en & ~I_FIFO_RESET_CMD &
		(I_TRANSFER_CMD_CODE != mon_pkg::CMD_NONE);
	wire [1:0] cmd_mode = I_TARGET_CHANNEL_ADDR[mon_pkg::MODE_HI:
		mon_pkg::MODE_LO];
	wire wr_push = I_WR_VALID & O_WR_READY;
	wire buf_push = rd_mode & acc_en & ~fifo_empty & ~bc_ff[1] &
		~I_FIFO_RESET_CMD;
	wire buf_pop = O_RD_VALID & I_RD_READY;
	wire bcast = ~line_ff & (mode_ff == mon_pkg::MODE_BCAST) & ~rxa_ff;
	wire ack_now = wait_ff & mr_act;
	// Broadcast paces itself and never looks at acknowledgements
	wire tx_ready = ~hs_ff | (bcast ? (div_ff == '0) :
		(~wait_ff | ack_now));
	wire tx_abort = hs_ff & ~bcast & wait_ff & ~mr_act & miss_ff & seen_ff;

	// Sequencer: FIFO reset beats a command, a command beats a frame
	always_comb begin
		nxt_state = state_ff;
		nxt_mode = mode_ff;
		nxt_addr = addr_ff;
		nxt_hs = hs_ff;
		nxt_cont = cont_ff;
		nxt_rxa = rxa_ff;
		nxt_line = line_ff;
		nxt_wait = wait_ff;
		nxt_seen = seen_ff;
		nxt_miss = miss_ff;
		nxt_mx_n = mx_n_ff;
		nxt_mr_n = mr_n_ff;
		nxt_read = read_ff;
		nxt_abort = abort_ff;
		nxt_done = 1'b0;
		nxt_div = div_ff;
		nxt_rxn = rxn_ff;
		nxt_txd = txd_ff;
		tx_pop = 1'b0;
		rx_push = 1'b0;
		if (I_FIFO_RESET_CMD) begin
			nxt_state = mon_pkg::ST_IDLE;
			nxt_wait = 1'b0;
			nxt_mx_n = 1'b1;
			nxt_mr_n = 1'b1;
			nxt_read = 1'b0;
			nxt_abort = 1'b0;
		end else if (cmd_go) begin
			nxt_mode = cmd_mode;
			nxt_addr = I_TARGET_CHANNEL_ADDR[mon_pkg::ADDR_HI:0];
			nxt_hs = I_HANDSHAKE_SELECT;
			nxt_cont = (I_TRANSFER_CMD_CODE == mon_pkg::CMD_CONT) &
				I_HANDSHAKE_SELECT;
			nxt_line = (I_TRANSFER_CMD_CODE == mon_pkg::CMD_CONT) &
				~I_HANDSHAKE_SELECT;
			nxt_rxa = (I_TRANSFER_CMD_CODE == mon_pkg::CMD_TXRX) | nxt_line;
			nxt_miss = 1'b0;
			nxt_seen = 1'b0;
			nxt_wait = 1'b0;
			nxt_div = '0;
			nxt_rxn = '0;
			nxt_read = 1'b0;
			if (I_TRANSFER_CMD_CODE == mon_pkg::CMD_TX &&
				cmd_mode == mon_pkg::MODE_TEST) begin
				// Loop back: content stays put, read side opens
				nxt_read = 1'b1;
				nxt_done = 1'b1;
				nxt_mx_n = 1'b1;
				nxt_state = mon_pkg::ST_IDLE;
			end else if (nxt_rxa && fifo_empty) begin
				nxt_state = mon_pkg::ST_RX;
				nxt_mx_n = 1'b1;
			end else begin
				nxt_state = mon_pkg::ST_TX;
			end
		end else if (frame_p) begin
			case (state_ff)
				mon_pkg::ST_TX: begin
					nxt_div = (div_ff == mon_pkg::BCAST_LAST) ? '0 :
						div_ff + 2'h1;
					nxt_miss = wait_ff & ~mr_act;
					if (ack_now)
						nxt_seen = 1'b1;
					if (tx_abort) begin
						nxt_state = mon_pkg::ST_IDLE;
						nxt_abort = 1'b1;
						nxt_done = 1'b1;
						nxt_mx_n = 1'b1;
						nxt_wait = 1'b0;
					end else if (tx_ready && !fifo_empty) begin
						tx_pop = 1'b1;
						nxt_txd = mem[rp_ff];
						nxt_mx_n = 1'b0;
						nxt_wait = hs_ff & ~bcast;
					end else if (tx_ready) begin
						nxt_wait = 1'b0;
						nxt_miss = 1'b0;
						if (rxa_ff) begin
							nxt_state = mon_pkg::ST_RX;
							nxt_mx_n = 1'b1;
						end else begin
							nxt_state = mon_pkg::ST_IDLE;
							nxt_done = 1'b1;
							nxt_mx_n = ~cont_ff;
						end
					end
				end
				mon_pkg::ST_RX: begin
					nxt_mr_n = 1'b1;
					if (!hs_ff) begin
						rx_push = ~fifo_full;
						nxt_rxn = rxn_ff + 5'h01;
						if (nxt_rxn == rx_frames(mode_ff)) begin
							nxt_state = mon_pkg::ST_IDLE;
							nxt_done = 1'b1;
							nxt_read = 1'b1;
						end
					end else if (mx_act) begin
						nxt_miss = 1'b0;
						if (fifo_full) begin
							nxt_state = mon_pkg::ST_STALL;
							nxt_done = 1'b1;
						end else begin
							rx_push = 1'b1;
							nxt_mr_n = 1'b0;
						end
					end else if (miss_ff) begin
						nxt_state = mon_pkg::ST_IDLE;
						nxt_done = 1'b1;
						nxt_read = 1'b1;
					end else begin
						nxt_miss = 1'b1;
					end
				end
				default: begin
					nxt_mr_n = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			state_ff <= mon_pkg::ST_IDLE;
			{mode_ff, addr_ff, div_ff, rxn_ff, txd_ff} <= '0;
			{hs_ff, cont_ff, rxa_ff, line_ff, wait_ff, seen_ff} <= '0;
			{miss_ff, read_ff, abort_ff, done_ff} <= '0;
			{mx_n_ff, mr_n_ff} <= 2'h3;
		end else if (I_CE) begin
			state_ff <= nxt_state;
			{mode_ff, addr_ff, div_ff, rxn_ff, txd_ff} <=
				{nxt_mode, nxt_addr, nxt_div, nxt_rxn, nxt_txd};
			{hs_ff, cont_ff, rxa_ff, line_ff, wait_ff, seen_ff} <=
				{nxt_hs, nxt_cont, nxt_rxa, nxt_line, nxt_wait, nxt_seen};
			{miss_ff, read_ff, abort_ff, done_ff} <=
				{nxt_miss, nxt_read, nxt_abort, nxt_done};
			{mx_n_ff, mr_n_ff} <= {nxt_mx_n, nxt_mr_n};
		end
	end

	// FIFO: one writer and one reader at a time by construction
	wire fpush = wr_push | rx_push;
	wire fpop = tx_pop | buf_push;
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			{wp_ff, rp_ff, cnt_ff} <= '0;
		end else if (I_CE) begin
			if (I_FIFO_RESET_CMD) begin
				{wp_ff, rp_ff, cnt_ff} <= '0;
			end else begin
				wp_ff <= wp_ff + PW'(fpush);
				rp_ff <= rp_ff + PW'(fpop);
				cnt_ff <= cnt_ff + (PW+1)'(fpush) - (PW+1)'(fpop);
			end
		end
	end

	// Array has no reset: content is only read where count says valid
	always_ff @(posedge I_CLK) begin
		if (I_CE && fpush)
			mem[wp_ff] <= rx_push ? rx_byte : I_WR_DATA;
	end

	// Read buffer keeps words when the reader stalls
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			{bh_ff, bc_ff} <= '0;
			bd_ff <= '{default: '0};
		end else if (I_CE) begin
			if (I_FIFO_RESET_CMD) begin
				{bh_ff, bc_ff} <= '0;
			end else begin
				if (buf_push)
					bd_ff[bh_ff ^ bc_ff[0]] <= mem[rp_ff];
				bh_ff <= bh_ff ^ buf_pop;
				bc_ff <= bc_ff + 2'(buf_push) - 2'(buf_pop);
			end
		end
	end

	// Search: lowest active upstream channel wins
	logic srch_ff, found_ff;
	logic [5:0] faddr_ff;
	wire found_now = srch_ff & frame_p & ~(&scan_n);
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			{srch_ff, found_ff, faddr_ff} <= '0;
		end else if (I_CE) begin
			found_ff <= found_now;
			if (found_now)
				faddr_ff <= first_act(scan_n);
			if (!I_CM_INIT_SELECT || found_now)
				srch_ff <= 1'b0;
			else if (I_CHANNEL_SEARCH_ON)
				srch_ff <= 1'b1;
		end
	end

	// Outputs
	assign O_WR_READY = acc_en & ~rd_mode & ~fifo_full;
	assign O_RD_VALID = (bc_ff != '0);
	assign O_RD_DATA = bd_ff[bh_ff];
	assign O_FIFO_EMPTY_FLAG = fifo_empty & (bc_ff == '0);
	assign O_XFER_ACTIVE = ~idle_st;
	assign O_XFER_ABORTED = abort_ff;
	assign O_ACCESS_EN = acc_en;
	assign O_READ_MODE = rd_mode;
	assign O_COMMAND_DONE_IRQ = done_ff;
	assign O_CHANNEL_FOUND_IRQ = found_ff;
	assign O_FOUND_CHANNEL_ADDR = faddr_ff;
	assign O_TX_DATA = txd_ff;
	assign O_MX_N = mx_n_ff;
	assign O_MR_N = mr_n_ff;
	assign O_BCAST = bcast & ~idle_st;
	assign O_TX_SLOT = addr_ff;
	assign O_RX_SLOT = line_ff ? addr_ff + mon_pkg::SAME_LINE_OFS :
		addr_ff;

	// Checks
	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_RST);

	// One frame start with the remote transmit handshake bit idle
	sequence quiet_frame_s;
		frame_p && !mx_act;
	endsequence

	// The very next frame start is idle as well, not any later one
	sequence two_quiet_s;
		quiet_frame_s ##0 first_match(##[1:1000] frame_p) ##0 !mx_act;
	endsequence

	cont_hold_a: assert property (I_CE && done_ff && cont_ff && !abort_ff
		|-> !O_MX_N) else $error("continuous end dropped MX");
	fifo_bound_a: assert property (cnt_ff <= (PW+1)'(DEPTH))
		else $error("FIFO over depth");
	stall_noack_a: assert property (stall_st |-> O_MR_N && O_XFER_ACTIVE)
		else $error("stall acknowledged byte");
	reset_abort_a: assert property (I_CE && I_FIFO_RESET_CMD |=>
		idle_st && O_FIFO_EMPTY_FLAG && O_MX_N)
		else $error("FIFO reset did not abort");
	search_stop_a: assert property (found_ff |-> !srch_ff)
		else $error("search kept running");
	bcast_pace_a: assert property (tx_pop && hs_ff && bcast |->
		div_ff == '0) else $error("broadcast pace broken");
	test_loop_a: assert property (I_CE && cmd_go && cmd_mode ==
		mon_pkg::MODE_TEST && I_TRANSFER_CMD_CODE == mon_pkg::CMD_TX
		|=> done_ff && O_MX_N && rd_mode)
		else $error("test transmitted");
	// Both idle frames must fall inside one and the same receive transfer
	end_msg_a: assert property ((I_CE && hs_ff && !I_FIFO_RESET_CMD &&
		state_ff == mon_pkg::ST_RX) throughout two_quiet_s |=>
		!(state_ff == mon_pkg::ST_RX && hs_ff))
		else $error("end of message missed");
	nohs_rx_a: assert property (I_CE && done_ff && !hs_ff && rxa_ff &&
		read_ff |-> rxn_ff == rx_frames(mode_ff))
		else $error("wrong frame count");
endmodule

// *** dv/sub_model.sv ***
// Subscriber circuit on the far side of the monitor channel.
// Assumes the handler samples its pins near each frame's rising edge.
`timescale 1ns/100ps
module sub_model #(
	parameter int HALF = 8
) (
	// Clock and protocol choice
	input wire logic clk,
	input wire logic hs,
	// Handler's downstream pins
	input wire logic d_mx_n,
	input wire logic d_mr_n,
	input wire logic [7:0] d_tx,
	// Upstream pins towards the handler
	output logic frame,
	output logic mr_n,
	output logic mx_n,
	output logic [7:0] rx
);
	logic [7:0] rq[$];
	logic [7:0] got[$];
	logic mute = 1'b0;
	logic sent = 1'b0;
	int acks = 0;

	// Pins move mid frame, so they are steady at the frame edge
	initial begin
		frame = 1'b0;
		mr_n = 1'b1;
		mx_n = 1'b1;
		rx = 8'h00;
		forever begin
			repeat (HALF) @(posedge clk);
			#1 frame = 1'b1;
			repeat (HALF) @(posedge clk);
			#1 frame = 1'b0;
			// One ack per byte, then a frame of rest before the next
			if (!d_mx_n && (!hs || (mr_n && !mute)))
				got.push_back(d_tx);
			mr_n = !(hs && !d_mx_n && mr_n && !mute);
			// With handshake, a reply byte is held until the handler acknowledges it; without, one is dropped per frame
			if (sent && rq.size() != 0 && (!hs || !d_mr_n)) begin
				void'(rq.pop_front());
				acks++;
			end
			sent = rq.size() != 0;
			mx_n = !sent; // Pulled up once released
			rx = sent ? rq[0] : ~rx; // Released line never holds its value
		end
	end
endmodule

// *** dv/tb_monitor_channel_command_handler.sv ***
// Self-checking bench of the monitor channel command handler.
// Assumes sub_model stands in for the subscriber circuits.
`timescale 1ns/100ps
module tb_monitor_channel_command_handler;
	localparam int FR = 16; // Clocks per frame
	logic clk, rst, cmd_v, ffr, son, hs, init, wv, rr, wr, rv, bc, rmode;
	logic empty, act, done, found, frame, mr_n, mx_n, omx, omr, abrt, acc;
	logic [1:0] code;
	logic [7:0] addr, wd, rd, txd, rxd;
	logic [5:0] faddr, tslot, rslot;
	logic [31:0] scan;
	logic [31:0] lf = 32'h0000_3f11;
	logic [7:0] mdl[$];
	int err_count = 0;
	int tests_run = 0;
	int dcnt = 0;
	int fcnt = 0;
	int wc;

	monitor_channel_command_handler uut (.I_CLK(clk), .I_RST(rst),
		.I_CE(1'b1), .I_CMD_VALID(cmd_v), .I_TRANSFER_CMD_CODE(code),
		.I_TARGET_CHANNEL_ADDR(addr), .I_FIFO_RESET_CMD(ffr),
		.I_CHANNEL_SEARCH_ON(son), .I_HANDSHAKE_SELECT(hs),
		.I_CM_INIT_SELECT(init), .I_WR_VALID(wv), .I_WR_DATA(wd),
		.O_WR_READY(wr), .O_RD_VALID(rv), .O_RD_DATA(rd), .I_RD_READY(rr),
		.O_FIFO_EMPTY_FLAG(empty), .O_XFER_ACTIVE(act),
		.O_XFER_ABORTED(abrt), .O_ACCESS_EN(acc), .O_READ_MODE(rmode),
		.O_COMMAND_DONE_IRQ(done),
		.O_CHANNEL_FOUND_IRQ(found), .O_FOUND_CHANNEL_ADDR(faddr),
		.I_FRAME(frame), .I_MR_N(mr_n), .I_MX_N(mx_n), .I_RX_DATA(rxd),
		.I_SCAN_MX_N(scan), .O_TX_DATA(txd), .O_MX_N(omx), .O_MR_N(omr),
		.O_BCAST(bc), .O_TX_SLOT(tslot), .O_RX_SLOT(rslot));
	sub_model #(.HALF(FR / 2)) sm (.clk(clk), .hs(hs), .d_mx_n(omx),
		.d_mr_n(omr), .d_tx(txd), .frame(frame), .mr_n(mr_n),
		.mx_n(mx_n), .rx(rxd));

	// Free-running 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Count the one-cycle event pulses
	always @(posedge clk) begin
		if (done === 1'b1) dcnt++;
		if (found === 1'b1) fcnt++;
	end
	// Cut a hang short: all tests need well under this span
	initial begin
		repeat (60000) @(posedge clk);
		err_count++;
		test_done();
	end

	// Fixed-seed LFSR feeds data bytes and read stalls
	function automatic logic [7:0] nxt();
		lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		return lf[7:0];
	endfunction
	task automatic tick();
		@(posedge clk);
		#1;
	endtask
	task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %s expected %0h seen %0h", nm, e, s);
		end
	endtask
	// Valid stays up across bytes, so it is never lowered and raised at once
	task automatic wr_b(int n);
		wv = 1'b1;
		for (int i = 0; i < n; i++) begin
			wd = nxt();
			while (wr !== 1'b1) tick();
			mdl.push_back(wd);
			tick();
		end
		wv = 1'b0;
	endtask
	task automatic cmd(logic [1:0] c, logic [7:0] a);
		code = c;
		addr = a;
		cmd_v = 1'b1;
		tick();
		cmd_v = 1'b0;
	endtask
	task automatic frst();
		ffr = 1'b1;
		tick();
		ffr = 1'b0;
	endtask
	task automatic srch();
		son = 1'b1;
		tick();
		son = 1'b0;
	endtask
	task automatic wdone(int lim);
		int d0;
		d0 = dcnt;
		for (wc = 0; wc < lim && dcnt == d0; wc++) tick();
		chk("done", d0 + 1, dcnt);
	endtask
	// The reply is queued for the partner and expected in the FIFO
	task automatic reply(int k);
		logic [7:0] b;
		for (int i = 0; i < k; i++) begin
			b = nxt();
			sm.rq.push_back(b);
			mdl.push_back(b);
		end
	endtask
	task automatic cmp_got();
		while (mdl.size() != 0 && sm.got.size() != 0)
			chk("tx_byte", mdl.pop_front(), sm.got.pop_front());
		chk("tx_left", 0, mdl.size() + sm.got.size());
	endtask
	// Drain with random stalls; data is compared while the model has some
	task automatic rd_all(int n);
		logic [7:0] b;
		int k;
		k = 0;
		for (int g = 0; g < 500 && k < n; g++) begin
			b = nxt();
			rr = b[0];
			if (rv === 1'b1 && rr) begin
				if (mdl.size() != 0) chk("rd_data", mdl.pop_front(), rd);
				k++;
			end
			tick();
		end
		rr = 1'b0;
		tick();
		chk("rd_count", n, k);
		chk("empty", 1, empty);
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Main sequence
	initial begin
		int n[4] = '{1, 2, 8, 16};
		{cmd_v, ffr, son, hs, wv, rr} = 6'h00;
		{init, code, addr, wd, scan} = {1'b1, 18'h0_0000, 32'hffff_ffff};
		rst = 1'b1;
		repeat (3) @(posedge clk);
		#1 rst = 1'b0;
		chk("rst_state", 5'h1e, {empty, wr, omx, omr, act});
		$display("done reset");
		wr_b(16);
		chk("full", 0, wr);
		cmd(mon_pkg::CMD_TX, {mon_pkg::MODE_TEST, 6'h00});
		wdone(4);
		chk("read_mode", 1, rmode);
		rd_all(16);
		frst();
		$display("done test operation");
		wr_b(3);
		cmd(mon_pkg::CMD_TX, 8'h05);
		wdone(8 * FR);
		cmp_got();
		wr_b(1);
		cmd(mon_pkg::CMD_CONT, 8'h03);
		tick();
		chk("slots", 12'h0c7, {tslot, rslot});
		wdone(8 * FR);
		cmp_got();
		frst();
		$display("done plain and same line");
		// Every receive count without handshake
		for (int s = 0; s < 4; s++) begin
			wr_b(1);
			for (int i = 0; i < 24; i++) sm.rq.push_back(nxt());
			cmd(mon_pkg::CMD_TXRX, {s[1:0], 6'h02});
			wdone(24 * FR);
			cmp_got();
			rd_all(n[s]);
			frst();
			sm.rq.delete();
		end
		$display("done receive counts");
		hs = 1'b1;
		wr_b(2);
		cmd(mon_pkg::CMD_TXRX, 8'h09);
		for (int g = 0; g < 20 * FR && sm.got.size() < 2; g++) tick();
		cmp_got();
		sm.acks = 0;
		reply(3);
		wdone(20 * FR);
		chk("acks", 3, sm.acks);
		rd_all(3);
		frst();
		sm.acks = 0;
		cmd(mon_pkg::CMD_TXRX, 8'h09);
		reply(18);
		wdone(60 * FR);
		chk("stall", 2'h3, {act, omr});
		rd_all(16);
		cmd(mon_pkg::CMD_TXRX, 8'h09);
		wdone(20 * FR);
		chk("acks", 18, sm.acks);
		rd_all(2);
		frst();
		$display("done handshake receive");
		// Partner acks the first byte, then falls silent for two frames
		wr_b(3);
		cmd(mon_pkg::CMD_TX, 8'h09);
		for (int g = 0; g < 20 * FR && sm.got.size() < 1; g++) tick();
		sm.mute = 1'b1;
		wdone(20 * FR);
		chk("aborted", 1, abrt);
		chk("tx_byte", mdl.pop_front(), sm.got.pop_front());
		frst();
		chk("abort_clr", 0, abrt);
		chk("access", 1, acc);
		sm.mute = 1'b0;
		sm.got.delete();
		mdl.delete();
		$display("done transmit abort");
		wr_b(16);
		cmd(mon_pkg::CMD_CONT, 8'h09);
		wdone(60 * FR);
		chk("mx_held", 0, omx);
		wr_b(1);
		cmd(mon_pkg::CMD_TX, 8'h09);
		wdone(8 * FR);
		cmp_got();
		// Broadcast with a silent partner must still finish on its own
		sm.mute = 1'b1;
		wr_b(2);
		cmd(mon_pkg::CMD_TX, {mon_pkg::MODE_BCAST, 6'h00});
		chk("bcast", 1, bc);
		wdone(20 * FR);
		chk("pace", 1, wc >= 3 * FR && wc <= 9 * FR);
		sm.mute = 1'b0;
		mdl.delete();
		$display("done continuous and broadcast");
		sm.acks = 0;
		cmd(mon_pkg::CMD_TXRX, 8'h09);
		reply(6);
		for (int g = 0; g < 20 * FR && sm.acks < 2; g++) tick();
		frst();
		chk("abort", 3'h3, {act, empty, omr});
		sm.rq.delete();
		mdl.delete();
		srch();
		repeat (2 * FR) tick();
		chk("no_find", 0, fcnt);
		frst();
		{scan[20], scan[9]} = 2'h0;
		repeat (4 * FR) tick();
		chk("found", 1, fcnt);
		chk("found_addr", 9, faddr);
		init = 1'b0;
		srch();
		repeat (3 * FR) tick();
		init = 1'b1;
		repeat (2 * FR) tick();
		chk("stopped", 1, fcnt);
		// A running search must die when the control memory is initialised
		scan = '1;
		srch();
		repeat (2 * FR) tick();
		init = 1'b0;
		tick();
		init = 1'b1;
		scan[5] = 1'b0;
		repeat (3 * FR) tick();
		chk("init_stop", 1, fcnt);
		$display("done abort and search");
		test_done();
	end
endmodule
